// file: common/stx_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the serial transmit block.
 * Assumes byte addressing on a 32-bit AHB-Lite bus, one word a register.
 */
// Function
// - bit six picks nine or eight data bits
// - bit five switches transmitter on or off
// - bit four selects synchronous or asynchronous operation
// - hardware clears break request; ignored when synchronous
// - bit two picks high speed, asynchronous only
// - bit one reads one while shifter empty
// - upper divisor byte readable, writable, reset zero
// - upper byte used only with wide divisor
// - writing upper byte restarts the baud counter
`ifndef STX_REGS_VH
`define STX_REGS_VH

// ============================================================
// Register offsets (byte addresses)
`define STX_OFF_CTRL 8'h00
`define STX_OFF_BAUD_LO 8'h04
`define STX_OFF_BAUD_HI 8'h08
`define STX_OFF_BAUD_CTL 8'h0c
`define STX_OFF_DATA 8'h10
`define STX_OFF_FIFO 8'h14

// ============================================================
// Field positions of transmit_status_control
`define STX_B_NINE 6
`define STX_B_ON 5
`define STX_B_SYNC 4
`define STX_B_BRK 3
`define STX_B_HIGH 2
`define STX_B_EMPTY 1
`define STX_B_NINTH 0
// Field positions of the baud control and FIFO status registers
`define STX_B_WIDE 3
`define STX_B_FEMPTY 8
`define STX_B_FFULL 9
`define STX_B_OVF 16

// ============================================================
// Reset values
`define STX_RST_CTRL 8'h02
`define STX_RST_BAUD_HI 8'h00
`define STX_RST_BAUD_LO 8'h00

// ============================================================
// Timing counts in baud ticks per bit
`define STX_TICKS_LOW 5'h10
`define STX_TICKS_HIGH 5'h04
`define STX_TICKS_SYNC 5'h04
// Frame lengths in bits
`define STX_LEN_BRK 4'he
`define STX_LEN_A8 4'ha
`define STX_LEN_A9 4'hb
`define STX_LEN_S8 4'h8
`define STX_LEN_S9 4'h9

`endif

// file: hw/stx_baud.v
/*
 * Baud rate counter: one tick every divisor+1 clock cycles.
 * Assumes the divisor is already narrowed by the caller.
 */
`timescale 1ns/100ps
`default_nettype none

module stx_baud (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire [15:0] divisor,
  input wire restart,
  // Tick out
  output reg tick
);
  reg [15:0] cnt_q;

  // Down counter; a restart reloads it without a tick, so the next
  // period is a whole one.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_q <= divisor;
      tick <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= divisor;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // stx_baud

`default_nettype wire

// file: hw/stx_fifo.v
/*
 * Synchronous FIFO of flip-flops with valid/ready on both sides.
 * Assumes one clock; both sides sample on the same edge.
 */
`timescale 1ns/100ps
`default_nettype none

module stx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level
  output wire [$clog2(DEPTH):0] count
);
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // Full and empty come from the level, so neither can lie.
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is not reset; only the pointers and the level carry control state.
  always @(posedge hclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, which is meant to be a power of two.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // stx_fifo

`default_nettype wire

// file: hw/stx_top.v
/*
 * Serial transmitter with AHB-Lite register slave, 16-word data FIFO,
 * baud counter and asynchronous or clocked synchronous shifter.
 * Assumes one bus master, single word transfers, and receive enables
 * arriving from neighbouring logic on the same clock.
 */
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "stx_regs.vh"

module stx_top (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Receive enables from the receiver
  input wire single_receive_enable,
  input wire continuous_receive_enable,
  // Serial line and clock pins
  output wire tx_line,
  output reg tx_line_oe,
  output reg sck_out,
  output reg sck_oe
);
  // ============================================================
  // State encodings
  localparam ST_IDLE = 3'b001;
  localparam ST_ASH = 3'b010;
  localparam ST_SSH = 3'b100;

  // ============================================================
  // Declarations
  reg [7:0] ctrl_q;
  reg [7:0] baud_lo_q;
  reg [7:0] baud_hi_q;
  reg wide_q;
  reg ovf_q;
  reg ph_wr_q;
  reg ph_rd_q;
  reg [7:0] ph_off_q;
  reg [2:0] state_q;
  reg [13:0] shreg_q;
  reg [3:0] left_q;
  reg [4:0] sub_q;
  reg brk_q;
  wire addr_ok;
  wire do_wr;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_pop;
  wire [7:0] fifo_data;
  wire [4:0] fifo_count;
  wire finish;
  wire drop;
  wire active;
  wire sync_mode;
  wire tick;
  wire start_brk;
  wire start_chr;
  wire bit_end;
  wire frame_done;
  wire hi_wr;
  wire [15:0] divisor;
  wire [4:0] ticks;
  wire [4:0] sub_d;

  // ============================================================
  // Functions

  // Ticks per bit; speed select matters only in asynchronous mode.
  function [4:0] bit_ticks;
    input sync;
    input high;
    begin
      if (sync) begin
        bit_ticks = `STX_TICKS_SYNC;
      end else if (high) begin
        bit_ticks = `STX_TICKS_HIGH;
      end else begin
        bit_ticks = `STX_TICKS_LOW;
      end
    end
  endfunction

  // Register read multiplexer; unmapped offsets read zero.
  function [31:0] rd_mux;
    input [7:0] off;
    begin
      case (off)
        `STX_OFF_CTRL: rd_mux = {24'h000000, 1'b0, ctrl_q[6:2],
                                 (state_q == ST_IDLE), ctrl_q[0]};
        `STX_OFF_BAUD_LO: rd_mux = {24'h000000, baud_lo_q};
        `STX_OFF_BAUD_HI: rd_mux = {24'h000000, baud_hi_q};
        `STX_OFF_BAUD_CTL: rd_mux = {28'h0000000, wide_q, 3'h0};
        `STX_OFF_FIFO: rd_mux = {15'h0000, ovf_q, 6'h00,
                                 !fifo_in_ready, !fifo_out_valid,
                                 3'h0, fifo_count};
        default: rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  // ============================================================
  // Bus decode
  // Reads take one wait state and data writes one or more, so that a read always
  // sees the write before it and a data write can wait for FIFO room.
  assign addr_ok = hsel & htrans[1] & hready;
  assign do_wr = ph_wr_q & hreadyout;
  assign hi_wr = do_wr & (ph_off_q == `STX_OFF_BAUD_HI);
  assign drop = ph_wr_q & !hreadyout & !fifo_in_ready & !active;
  assign finish = ph_wr_q & !hreadyout & (fifo_in_ready | !active);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_off_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (ph_rd_q && !hreadyout) begin
        hrdata <= rd_mux(ph_off_q);
        hreadyout <= 1'b1;
        ph_rd_q <= 1'b0;
      end else if (finish) begin
        hreadyout <= 1'b1;
        ph_wr_q <= 1'b0;
      end else if (hreadyout) begin
        ph_wr_q <= addr_ok & hwrite;
        ph_rd_q <= addr_ok & !hwrite;
        ph_off_q <= haddr[7:0];
        hreadyout <= !(addr_ok &
                       (!hwrite | (haddr[7:0] == `STX_OFF_DATA)));
      end
    end
  end

  // ============================================================
  // Control registers
  // A software write of the break bit is a set and beats the hardware
  // clear of the same cycle; the shifter status bit is read only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `STX_RST_CTRL;
      baud_lo_q <= `STX_RST_BAUD_LO;
      baud_hi_q <= `STX_RST_BAUD_HI;
      wide_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (frame_done && brk_q) begin
        ctrl_q[`STX_B_BRK] <= 1'b0;
      end
      if (do_wr && (ph_off_q == `STX_OFF_CTRL)) begin
        ctrl_q[`STX_B_NINE] <= hwdata[`STX_B_NINE];
        ctrl_q[`STX_B_ON] <= hwdata[`STX_B_ON];
        ctrl_q[`STX_B_SYNC] <= hwdata[`STX_B_SYNC];
        ctrl_q[`STX_B_HIGH] <= hwdata[`STX_B_HIGH];
        ctrl_q[`STX_B_NINTH] <= hwdata[`STX_B_NINTH];
        if (hwdata[`STX_B_BRK]) begin
          ctrl_q[`STX_B_BRK] <= 1'b1;
        end
      end
      if (do_wr && (ph_off_q == `STX_OFF_BAUD_LO)) begin
        baud_lo_q <= hwdata[7:0];
      end
      if (hi_wr) begin
        baud_hi_q <= hwdata[7:0];
      end
      if (do_wr && (ph_off_q == `STX_OFF_BAUD_CTL)) begin
        wide_q <= hwdata[`STX_B_WIDE];
      end
      // Overflow is write-one-to-clear; a new drop wins over the clear.
      if (drop) begin
        ovf_q <= 1'b1;
      end else if (do_wr && (ph_off_q == `STX_OFF_FIFO) &&
                   hwdata[`STX_B_OVF]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Data FIFO and baud counter
  // The receive enables override the transmitter in synchronous mode.
  assign sync_mode = ctrl_q[`STX_B_SYNC];
  assign active = ctrl_q[`STX_B_ON] &
                  !(sync_mode & (single_receive_enable |
                                 continuous_receive_enable));
  assign divisor = wide_q ? {baud_hi_q, baud_lo_q}
                          : {8'h00, baud_lo_q};
  assign ticks = bit_ticks(sync_mode, ctrl_q[`STX_B_HIGH]);

  stx_fifo #(
    .WIDTH(8),
    .DEPTH(16)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(ph_wr_q & !hreadyout),
    .in_ready(fifo_in_ready),
    .in_data(hwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  // Starting a frame also restarts the counter so its first bit is whole.
  stx_baud u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor(divisor),
    .restart(hi_wr | start_brk | start_chr),
    .tick(tick)
  );

  // ============================================================
  // Shifter
  // A pending break is ignored while synchronous.
  assign start_brk = (state_q == ST_IDLE) & active & !sync_mode &
                     ctrl_q[`STX_B_BRK];
  assign start_chr = (state_q == ST_IDLE) & active & !start_brk &
                     fifo_out_valid;
  assign fifo_pop = start_chr;
  assign bit_end = tick & (sub_q == ticks - 5'h01);
  assign frame_done = bit_end & (left_q == 4'h1);
  // Next sub-bit count; the clock output follows it so it stays in phase.
  assign sub_d = bit_end ? 5'h00 : (tick ? sub_q + 5'h01 : sub_q);

  // The line bit is shreg_q[0]; idle fills with ones keep it high.
  assign tx_line = shreg_q[0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      shreg_q <= 14'h3fff;
      left_q <= 4'h0;
      sub_q <= 5'h00;
      brk_q <= 1'b0;
      tx_line_oe <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      tx_line_oe <= active;
      sck_oe <= active & sync_mode;
      case (state_q)
        ST_IDLE: begin
          sub_q <= 5'h00;
          sck_out <= 1'b0;
          shreg_q <= 14'h3fff;
          if (start_brk) begin
            shreg_q <= {1'b1, 12'h000, 1'b0};
            left_q <= `STX_LEN_BRK;
            brk_q <= 1'b1;
            state_q <= ST_ASH;
          end else if (start_chr && !sync_mode) begin
            if (ctrl_q[`STX_B_NINE]) begin
              shreg_q <= {4'hf, ctrl_q[`STX_B_NINTH], fifo_data,
                          1'b0};
              left_q <= `STX_LEN_A9;
            end else begin
              shreg_q <= {5'h1f, fifo_data, 1'b0};
              left_q <= `STX_LEN_A8;
            end
            state_q <= ST_ASH;
          end else if (start_chr) begin
            shreg_q <= {5'h1f, ctrl_q[`STX_B_NINTH], fifo_data};
            left_q <= ctrl_q[`STX_B_NINE] ? `STX_LEN_S9
                                          : `STX_LEN_S8;
            state_q <= ST_SSH;
          end
        end
        ST_ASH, ST_SSH: begin
          if (!active) begin
            // Turning off aborts the frame and idles the line; a pending
            // break stays pending and goes out when turned on again.
            state_q <= ST_IDLE;
            shreg_q <= 14'h3fff;
            brk_q <= 1'b0;
            sck_out <= 1'b0;
          end else begin
            sub_q <= sub_d;
            // Synchronous clock: low in the first half of each bit, so
            // data changes on its falling edge and is steady at its rise.
            sck_out <= (state_q == ST_SSH) &
                       (sub_d >= {1'b0, ticks[4:1]});
            if (bit_end) begin
              shreg_q <= {1'b1, shreg_q[13:1]};
              left_q <= left_q - 4'h1;
              // The last bit ends the frame and any break with it.
              if (frame_done) begin
                state_q <= ST_IDLE;
                brk_q <= 1'b0;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // stx_top

`default_nettype wire

// file: test/stx_chk.sv
/* Port checker of the serial transmitter top.
   Assumes a single bus master whose hready is the slave's hreadyout. */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Checker
module stx_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Line side
  input wire logic tx_line,
  input wire logic tx_line_oe,
  input wire logic sck_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A transfer is taken when selected, non-idle and the bus is ready.
  wire logic take = hsel && htrans[1] && hready;
  resp_okay_a: assert property (
    hresp == 1'b0) else $error("Slave gave an error response.");
  read_wait_a: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state.");
  hi_write_a: assert property (
    take && hwrite && haddr[7:0] == 8'h08 |=> hreadyout)
    else $error("Upper divisor write stalled.");
  rdata_hold_a: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("Read data moved without a read.");
  wait_bound_a: assert property (
    !hreadyout |-> ##[1:1000] hreadyout)
    else $error("Wait state never ended.");
  idle_high_a: assert property (
    !tx_line_oe |-> tx_line) else $error("Line not high while idle.");
  sck_line_a: assert property (
    sck_oe |-> tx_line_oe) else $error("Clock driven without the line.");
  low_hold_a: assert property (
    $fell(tx_line) && tx_line_oe |=> (!tx_line || !tx_line_oe)[*3])
    else $error("Low bit shorter than four cycles.");
endmodule // stx_chk
bind stx_top stx_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_line(tx_line), .tx_line_oe(tx_line_oe), .sck_oe(sck_oe));
`default_nettype wire

// file: test/stx_peer.sv
/* Remote asynchronous receiver watching the transmit line.
   Assumes the bench gives it the bit time in clock cycles. */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Receiver model
module stx_peer (
  // Clock
  input wire logic hclk,
  // Line level at the far end
  input wire logic line,
  // Receive settings
  input wire logic [31:0] bit_cycles,
  input wire logic [3:0] nbits,
  // Results
  output logic [8:0] rx_data,
  output logic [31:0] rx_count,
  output logic [31:0] low_run
);
  logic [31:0] run = 32'h0;
  logic [8:0] shift;
  int i;
  // Latch the length of each low stretch when the line rises again.
  always @(posedge hclk) begin
    if (line) begin
      if (run != 0) low_run <= run;
      run <= 32'h0;
    end else run <= run + 1;
  end
  // Sample each bit in its middle; a break decodes as zeros.
  initial begin
    rx_count = 0;
    rx_data = 9'h0;
    forever begin
      @(negedge line);
      repeat (bit_cycles / 2) @(posedge hclk);
      shift = 9'h0;
      for (i = 0; i < nbits; i++) begin
        repeat (bit_cycles) @(posedge hclk);
        shift[i] = line;
      end
      rx_data = shift;
      rx_count = rx_count + 1;
      repeat (bit_cycles) @(posedge hclk);
    end
  end
endmodule // stx_peer
`default_nettype wire

// file: test/test_serial_tx_control_baud_high.sv
/* Self-checking bench of the serial transmitter top.
   Assumes the register map of stx_regs.vh and a pulled-up line. */
`timescale 1ns/100ps
`default_nettype none
`include "stx_regs.vh"
// ==========
// Bench
module test_serial_tx_control_baud_high;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
  logic [1:0] htrans = 2'b00;
  logic sre = 1'b0;
  logic cre = 1'b0;
  logic [3:0] nb = 4'h8;
  logic [31:0] bitc = 32'h10;
  wire logic [31:0] hrdata, rxc, lrun;
  wire logic [8:0] rxd;
  wire logic hreadyout, hresp, tx_line, tx_line_oe, sck_out, sck_oe, line_w;
  int mismatches = 0, n_compared = 0, nrx = 0, i;
  stx_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .single_receive_enable(sre),
    .continuous_receive_enable(cre), .tx_line(tx_line),
    .tx_line_oe(tx_line_oe), .sck_out(sck_out), .sck_oe(sck_oe));
  stx_peer peer (.hclk(hclk), .line(line_w), .bit_cycles(bitc),
    .nbits(nb), .rx_data(rxd), .rx_count(rxc), .low_run(lrun));
  // A released line floats to the pull-up level.
  assign line_w = tx_line_oe ? tx_line : 1'b1;
  always #5 hclk = ~hclk;
  task results;
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready; data writes may stall while the FIFO is full.
  task wait_rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end
    while (hreadyout !== 1'b1 && n < 3000);
    if (n >= 3000) begin mismatches++; results; end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'b00; hwdata <= wd;
    wait_rdy;
    d = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd); bus(1'b1, a, wd);
  endtask
  task rd(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask
  task wait_rx;
    int n;
    n = 0;
    nrx++;
    while (rxc != nrx && n < 20000) begin @(posedge hclk); n++; end
    if (n >= 20000) begin mismatches++; results; end
  endtask
  // ==========
  // Scenarios
  task t_regs;
    rd(`STX_OFF_CTRL); check(d, {24'h0, `STX_RST_CTRL});
    rd(`STX_OFF_BAUD_HI); check(d, 32'h0);
    wr(`STX_OFF_BAUD_HI, 32'ha5); rd(`STX_OFF_BAUD_HI); check(d, 32'ha5);
    wr(`STX_OFF_BAUD_HI, 32'h0); rd(8'h3c); check(d, 32'h0);
  endtask
  task t_async;
    wr(`STX_OFF_CTRL, 32'h20); wr(`STX_OFF_DATA, 32'h55);
    wr(`STX_OFF_DATA, 32'hc3); rd(`STX_OFF_CTRL); check(d[1], 1'b0);
    wait_rx; check(rxd, 9'h055);
    wait_rx; check(rxd, 9'h0c3);
    repeat (40) @(posedge hclk);
    rd(`STX_OFF_CTRL); check(d[1], 1'b1);
  endtask
  task t_nine;
    bitc = 32'h4; nb = 4'h9;
    wr(`STX_OFF_CTRL, 32'h65); wr(`STX_OFF_DATA, 32'ha3);
    wait_rx; check(rxd, 9'h1a3);
    repeat (20) @(posedge hclk);
  endtask
  task t_break;
    nb = 4'h8; wr(`STX_OFF_CTRL, 32'h2c);
    wait_rx; repeat (40) @(posedge hclk);
    check((lrun + 2) / 4, 32'd13);
    rd(`STX_OFF_CTRL); check(d[3], 1'b0);
  endtask
  task t_wide;
    wr(`STX_OFF_CTRL, 32'h24); wr(`STX_OFF_BAUD_HI, 32'h1);
    wr(`STX_OFF_DATA, 32'h1); wait_rx; check(rxd, 9'h001);
    repeat (20) @(posedge hclk);
    wr(`STX_OFF_BAUD_CTL, 32'h8); bitc = 32'd1028;
    // Rewriting the upper byte in mid start bit restarts its period.
    wr(`STX_OFF_DATA, 32'h1); repeat (100) @(posedge hclk);
    wr(`STX_OFF_BAUD_HI, 32'h1); wait_rx;
    check((lrun + 514) / 1028, 32'd1);
    check(lrun >= 32'd1100 && lrun <= 32'd1160, 1'b1);
    repeat (1700) @(posedge hclk);
    wr(`STX_OFF_BAUD_CTL, 32'h0); wr(`STX_OFF_BAUD_HI, 32'h0); bitc = 32'h4;
  endtask
  task t_fifo;
    wr(`STX_OFF_CTRL, 32'h04);
    for (i = 0; i < 17; i++) wr(`STX_OFF_DATA, i);
    rd(`STX_OFF_FIFO); check(d, 32'h10210);
    wr(`STX_OFF_FIFO, 32'h10000); wr(`STX_OFF_CTRL, 32'h24);
    nrx = nrx + 15; wait_rx; check(rxd, 9'h00f);
    repeat (40) @(posedge hclk);
    rd(`STX_OFF_FIFO); check(d, 32'h100);
  endtask
  task t_sync;
    int n, k;
    logic p;
    logic [7:0] b;
    sre <= 1'b1; wr(`STX_OFF_CTRL, 32'h30); wr(`STX_OFF_DATA, 32'h0f);
    repeat (30) @(posedge hclk);
    check(tx_line_oe, 1'b0);
    sre <= 1'b0; cre <= 1'b1;
    repeat (10) @(posedge hclk);
    check(tx_line_oe, 1'b0);
    cre <= 1'b0;
    n = 0;
    while (sck_oe !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    check(sck_oe, 1'b1);
    // Take the line at each clock rise; bits go out LSB first.
    k = 0; p = 1'b0; b = 8'h00;
    for (n = 0; n < 60; n++) begin
      @(posedge hclk);
      if (sck_out === 1'b1 && p === 1'b0) begin
        b = {tx_line, b[7:1]}; k++;
      end
      p = sck_out;
    end
    check(k, 8);
    check(b, 8'h0f);
  endtask
  // Reset for eight cycles, then run every scenario.
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs; t_async; t_nine; t_break; t_wide; t_fifo; t_sync;
    results;
  end
endmodule // test_serial_tx_control_baud_high
`default_nettype wire
